// ### rtl/aomc_dev.sv
// device end: operating mode sequencer with coefficient storage
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01 - mode field bits 5:2, reset continuous
// RULE_02 - codes 1001 to 1111 do nothing
// RULE_03 - single mode runs one full-settle conversion
// RULE_04 - single done: store, ready low, standby
// RULE_05 - hold result and ready until read
// RULE_06 - data read returns ready high
// RULE_07 - standby powers down, keeps registers
// RULE_08 - standby: four supply enables host-controlled
// RULE_09 - standby keeps diagnostics, accepts changes
// RULE_10 - clock diagnostics dead if enabled in standby
// RULE_11 - power-down clears everything; the control register keeps its contents
// RULE_12 - host rewrites registers after power-down
// RULE_13 - idle holds filter, clocks keep running
// RULE_14 - zero cal: short input, ready high then low
// RULE_15 - zero cal one period, store offset, idle
// RULE_16 - host enables one channel for zero cal
// RULE_17 - full cal: store gain, ready low, idle
// RULE_18 - full cal takes four settle periods
// RULE_19 - host avoids full cal at unity gain
// RULE_20 - host avoids full cal in full power
// RULE_21 - host runs full cal before zero cal
// RULE_22 - host resets offset before full cal
// RULE_23 - host recalibrates after gain change
// RULE_24 - new mode acts once write completes
module aomc_dev #(
	parameter int SETTLE = aomc_pkg::SETTLE_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	aomc_if.dev bus,
	input wire logic [3:0] sel_ch,
	input wire logic [23:0] conv_in,
	input wire logic conv_valid,
	input wire logic [3:0] stby_en,
	output logic [3:0] mode,
	output logic mod_run,
	output logic filt_rst,
	output logic in_short,
	output logic in_fullscale,
	output logic regs_on,
	output logic [3:0] supply_en,
	output logic [7:0] diag_active,
	output logic [23:0] offs_sel,
	output logic [23:0] gain_sel
);
	import aomc_pkg::*;

	typedef enum logic [2:0] {
		S_RUN, S_SINGLE, S_STBY, S_PDOWN, S_IDLE, S_ZCAL, S_FCAL
	} aomc_st_e;

	localparam int CNT_W = $clog2(SETTLE * FCAL_PERIODS + 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	aomc_st_e st_q, st_d;
	logic [15:0] ctrl_q, ctrl_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [23:0] data_q, data_d;
	logic rdy_b_q, rdy_b_d;
	logic [7:0] diag_q, diag_d;
	logic [7:0] diag_ok_q, diag_ok_d;
	logic [3:0] cal_ch_q, cal_ch_d;
	logic [23:0] offs_q [NCH];
	logic [23:0] gain_q [NCH];
	logic offs_we, gain_we;
	logic [3:0] coef_ch;
	logic [23:0] coef_val;

	function automatic logic [CNT_W-1:0] periods(input int n);
		periods = CNT_W'(SETTLE * n);
	endfunction

	function automatic aomc_st_e mode_state(input logic [3:0] m);
		unique case (m)
			MODE_CONT: mode_state = S_RUN;
			MODE_SINGLE: mode_state = S_SINGLE;
			MODE_STBY: mode_state = S_STBY;
			MODE_PDOWN: mode_state = S_PDOWN;
			MODE_IDLE: mode_state = S_IDLE;
			MODE_ZCAL: mode_state = S_ZCAL;
			MODE_FCAL: mode_state = S_FCAL;
			default: mode_state = S_IDLE;
		endcase
	endfunction

	wire logic ctrl_wr = bus.wr_stb && bus.wr_tgt == AOMC_TGT_CTRL;
	wire logic [3:0] new_mode = bus.wr_data[MODE_MSB:MODE_LSB];
	wire logic rsv = new_mode >= MODE_RSV_LO;

	// ----------------------------------------------------------------
	// mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		ctrl_d = ctrl_q;
		cnt_d = cnt_q;
		data_d = data_q;
		rdy_b_d = rdy_b_q;
		diag_d = diag_q;
		diag_ok_d = diag_ok_q;
		cal_ch_d = cal_ch_q;
		offs_we = 1'b0;
		gain_we = 1'b0;
		coef_ch = cal_ch_q;
		coef_val = conv_in;
		if (bus.rd_data_stb) begin
			rdy_b_d = 1'b1; // [RULE_06]
		end
		unique case (st_q)
			S_RUN: begin
				if (conv_valid) begin
					data_d = conv_in;
					rdy_b_d = 1'b0;
				end
			end
			S_SINGLE: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1; // [RULE_03]
				end else if (conv_valid) begin
					data_d = conv_in; // [RULE_04]
					rdy_b_d = 1'b0; // [RULE_05]
					st_d = S_STBY;
					ctrl_d[MODE_MSB:MODE_LSB] = MODE_STBY;
				end
			end
			S_ZCAL, S_FCAL: begin
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 1'b1; // [RULE_18]
				end else if (conv_valid) begin
					offs_we = st_q == S_ZCAL; // [RULE_15]
					gain_we = st_q == S_FCAL; // [RULE_17]
					rdy_b_d = 1'b0; // [RULE_14]
					st_d = S_IDLE;
					ctrl_d[MODE_MSB:MODE_LSB] = MODE_IDLE;
				end
			end
			S_STBY, S_IDLE, S_PDOWN: begin
			end
		endcase
		if (bus.wr_stb && bus.wr_tgt == AOMC_TGT_DIAG) begin
			diag_d = bus.wr_data[7:0]; // [RULE_09]
			// clock diagnostics only arm outside standby
			diag_ok_d = (st_q == S_STBY) ?
				(diag_ok_q & bus.wr_data[7:0]) : bus.wr_data[7:0]; // [RULE_10]
		end
		if (ctrl_wr && !rsv) begin
			ctrl_d = bus.wr_data[15:0]; // [RULE_01]
			// a mode write drops a result landing in the same cycle
			data_d = data_q; // [RULE_24]
			rdy_b_d = rdy_b_q || bus.rd_data_stb;
			offs_we = 1'b0;
			gain_we = 1'b0;
			st_d = mode_state(new_mode); // [RULE_24]
			cal_ch_d = sel_ch;
			unique case (new_mode)
				MODE_SINGLE: cnt_d = periods(1);
				MODE_ZCAL: begin
					cnt_d = periods(ZCAL_PERIODS);
					rdy_b_d = 1'b1; // [RULE_14]
				end
				MODE_FCAL: begin
					cnt_d = periods(FCAL_PERIODS); // [RULE_18]
					rdy_b_d = 1'b1; // [RULE_17]
				end
				default: cnt_d = '0;
			endcase
		end else if (ctrl_wr) begin
			// reserved code: other fields taken, mode unchanged
			ctrl_d = {bus.wr_data[15:6], ctrl_q[5:2], bus.wr_data[1:0]};
		end // [RULE_02]
		if (st_q == S_PDOWN && !(ctrl_wr && !rsv)) begin
			data_d = DATA_RST; // [RULE_11]
			rdy_b_d = 1'b1;
			diag_d = '0;
			diag_ok_d = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st_q <= S_RUN;
			ctrl_q <= CTRL_RST;
			cnt_q <= '0;
			data_q <= DATA_RST;
			rdy_b_q <= 1'b1;
			diag_q <= '0;
			diag_ok_q <= '0;
			cal_ch_q <= '0;
		end else begin
			st_q <= st_d;
			ctrl_q <= ctrl_d;
			cnt_q <= cnt_d;
			data_q <= data_d;
			rdy_b_q <= rdy_b_d;
			diag_q <= diag_d;
			diag_ok_q <= diag_ok_d;
			cal_ch_q <= cal_ch_d;
		end
	end

	// ----------------------------------------------------------------
	// coefficient storage
	// ----------------------------------------------------------------
	wire logic pd_clr = st_q == S_PDOWN;
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!rst_b || pd_clr) begin
				offs_q[i] <= OFFS_RST; // [RULE_11]
				gain_q[i] <= GAIN_RST;
			end else begin
				if ((offs_we && coef_ch == 4'(i)) ||
					(bus.wr_stb && bus.wr_tgt == AOMC_TGT_OFFS &&
					bus.wr_ch == 4'(i))) begin
					offs_q[i] <= offs_we ? coef_val : bus.wr_data;
				end
				if ((gain_we && coef_ch == 4'(i)) ||
					(bus.wr_stb && bus.wr_tgt == AOMC_TGT_GAIN &&
					bus.wr_ch == 4'(i))) begin
					gain_q[i] <= gain_we ? coef_val : bus.wr_data;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign bus.rd_data = data_q;
	assign bus.rdy_b = rdy_b_q;
	assign mode = ctrl_q[MODE_MSB:MODE_LSB];
	assign mod_run = !(st_q inside {S_STBY, S_PDOWN}); // [RULE_13]
	assign filt_rst = st_q inside {S_IDLE, S_STBY, S_PDOWN}; // [RULE_13]
	assign in_short = st_q == S_ZCAL; // [RULE_14]
	assign in_fullscale = st_q == S_FCAL; // [RULE_17]
	assign regs_on = st_q != S_PDOWN; // [RULE_07]
	assign supply_en = (st_q == S_STBY) ? stby_en : // [RULE_08]
		((st_q == S_PDOWN) ? 4'h0 : 4'hF);
	assign diag_active = (st_q == S_PDOWN) ? 8'h00 :
		(diag_q & (diag_ok_q | ~DIAG_CLK_MASK)); // [RULE_10]
	assign offs_sel = offs_q[sel_ch];
	assign gain_sel = gain_q[sel_ch];
endmodule
`default_nettype wire

// ### rtl/aomc_pkg.sv
// package: constants and types shared by both ends of the mode controller
package aomc_pkg;
	// control register layout
	localparam int CTRL_W = 16;
	localparam int MODE_LSB = 2;
	localparam int MODE_MSB = 5;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [3:0] MODE_CONT = 4'h0;
	localparam logic [3:0] MODE_SINGLE = 4'h1;
	localparam logic [3:0] MODE_STBY = 4'h2;
	localparam logic [3:0] MODE_PDOWN = 4'h3;
	localparam logic [3:0] MODE_IDLE = 4'h4;
	localparam logic [3:0] MODE_ZCAL = 4'h5;
	localparam logic [3:0] MODE_FCAL = 4'h6;
	localparam logic [3:0] MODE_RSV_LO = 4'h9;
	// data path and coefficient layout
	localparam int DATA_W = 24;
	localparam logic [23:0] DATA_RST = 24'h000000;
	localparam logic [23:0] OFFS_RST = 24'h800000;
	localparam logic [23:0] GAIN_RST = 24'h500000;
	localparam int NCH = 16;
	// filter settling period in cycles of sys_clk (shortened by parameter)
	localparam int SETTLE_CYC = 64;
	localparam int FCAL_PERIODS = 4;
	localparam int ZCAL_PERIODS = 1;
	// standby enables: reference, oscillator, power switch, bias
	localparam int STBY_REF = 0;
	localparam int STBY_OSC = 1;
	localparam int STBY_PSW = 2;
	localparam int STBY_BIAS = 3;
	// diagnostic enable bits that need the master clock
	localparam logic [7:0] DIAG_CLK_MASK = 8'h1F;
	typedef enum logic [1:0] {
		AOMC_TGT_CTRL,
		AOMC_TGT_OFFS,
		AOMC_TGT_GAIN,
		AOMC_TGT_DIAG
	} aomc_tgt_e;
endpackage

// ### rtl/aomc_if.sv
// interface: write/read port between host and mode controller
`timescale 1ns/1ps
`default_nettype none
interface aomc_if;
	import aomc_pkg::*;
	logic wr_stb;
	aomc_tgt_e wr_tgt;
	logic [3:0] wr_ch;
	logic [23:0] wr_data;
	logic rd_data_stb;
	logic [23:0] rd_data;
	logic rdy_b;
	modport dev (
		input wr_stb, wr_tgt, wr_ch, wr_data, rd_data_stb,
		output rd_data, rdy_b
	);
	modport host (
		output wr_stb, wr_tgt, wr_ch, wr_data, rd_data_stb,
		input rd_data, rdy_b
	);
endinterface
`default_nettype wire

// ### rtl/aomc_host.sv
// host end: issues mode, coefficient and diagnostic writes, reads data
`timescale 1ns/1ps
`default_nettype none
module aomc_host (
	input wire logic sys_clk,
	input wire logic rst_b,
	aomc_if.host bus,
	input wire logic req,
	input wire aomc_pkg::aomc_tgt_e req_tgt,
	input wire logic [3:0] req_ch,
	input wire logic [23:0] req_data,
	input wire logic rd_req,
	input wire logic pwr_full,
	input wire logic gain_unity,
	output logic busy,
	output logic refused,
	output logic [23:0] data_out,
	output logic data_valid,
	output logic rdy_b
);
	import aomc_pkg::*;

	// ----------------------------------------------------------------
	// request issue
	// ----------------------------------------------------------------
	logic stb_q, stb_d;
	aomc_tgt_e tgt_q, tgt_d;
	logic [3:0] ch_q, ch_d;
	logic [23:0] dat_q, dat_d;
	logic rd_q, rd_d;
	logic [23:0] out_q, out_d;
	logic val_q, val_d;
	logic ref_q, ref_d;
	logic pd_q, pd_d;
	logic offs_ok_q, offs_ok_d;

	wire logic [3:0] m = req_data[MODE_MSB:MODE_LSB];
	wire logic fcal = req_tgt == AOMC_TGT_CTRL && m == MODE_FCAL;
	wire logic zcal = req_tgt == AOMC_TGT_CTRL && m == MODE_ZCAL;

	always_comb begin
		stb_d = 1'b0;
		tgt_d = tgt_q;
		ch_d = ch_q;
		dat_d = dat_q;
		rd_d = 1'b0;
		out_d = out_q;
		val_d = 1'b0;
		ref_d = 1'b0;
		pd_d = pd_q;
		offs_ok_d = offs_ok_q;
		if (rd_q) begin
			out_d = bus.rd_data;
			val_d = 1'b1;
		end
		if (req && (fcal && (gain_unity || pwr_full || // [RULE_19] [RULE_20]
			!offs_ok_q || pd_q))) begin // [RULE_22] [RULE_21] [RULE_12]
			ref_d = 1'b1;
		end else if (req) begin
			stb_d = 1'b1;
			tgt_d = req_tgt;
			ch_d = req_ch; // [RULE_16]
			dat_d = req_data;
			if (req_tgt == AOMC_TGT_OFFS) begin
				offs_ok_d = req_data == OFFS_RST;
			end
			if (fcal || zcal) begin
				offs_ok_d = 1'b0; // [RULE_23]
			end
			if (req_tgt == AOMC_TGT_CTRL) begin
				// leaving power-down: offsets must be rewritten first
				if (pd_q && m != MODE_PDOWN) begin
					offs_ok_d = 1'b0; // [RULE_12]
				end
				pd_d = m == MODE_PDOWN; // [RULE_12]
			end
		end else if (rd_req) begin
			rd_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			stb_q <= 1'b0;
			tgt_q <= AOMC_TGT_CTRL;
			ch_q <= '0;
			dat_q <= '0;
			rd_q <= 1'b0;
			out_q <= DATA_RST;
			val_q <= 1'b0;
			ref_q <= 1'b0;
			pd_q <= 1'b0;
			offs_ok_q <= 1'b1;
		end else begin
			stb_q <= stb_d;
			tgt_q <= tgt_d;
			ch_q <= ch_d;
			dat_q <= dat_d;
			rd_q <= rd_d;
			out_q <= out_d;
			val_q <= val_d;
			ref_q <= ref_d;
			pd_q <= pd_d;
			offs_ok_q <= offs_ok_d;
		end
	end

	assign bus.wr_stb = stb_q;
	assign bus.wr_tgt = tgt_q;
	assign bus.wr_ch = ch_q;
	assign bus.wr_data = dat_q;
	assign bus.rd_data_stb = rd_q;
	assign busy = stb_q || rd_q;
	assign refused = ref_q;
	assign data_out = out_q;
	assign data_valid = val_q;
	assign rdy_b = bus.rdy_b;
endmodule
`default_nettype wire

// ### tb/aomc_assertions.sv
// checker: timing relations on the host/device port
`timescale 1ns/1ps
`default_nettype none
module aomc_assertions #(
	parameter int SETTLE = aomc_pkg::SETTLE_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic wr_stb,
	input wire aomc_pkg::aomc_tgt_e wr_tgt,
	input wire logic [23:0] wr_data,
	input wire logic rd_data_stb,
	input wire logic [23:0] rd_data,
	input wire logic rdy_b
);
	import aomc_pkg::*;
	logic [3:0] kind_q, kind_d;
	logic [15:0] cnt_q, cnt_d;
	logic mwr;
	// ---------------------------------------------
	// cycles since the last accepted mode write
	// ---------------------------------------------
	assign mwr = wr_stb && wr_tgt == AOMC_TGT_CTRL &&
		wr_data[5:2] < MODE_RSV_LO;
	always_comb begin
		kind_d = mwr ? wr_data[5:2] : kind_q;
		cnt_d = mwr ? 16'h0000 : cnt_q + {15'h0000, cnt_q != 16'hFFFF};
	end
	always_ff @(posedge sys_clk) begin
		kind_q <= rst_b ? kind_d : MODE_CONT;
		cnt_q <= rst_b ? cnt_d : 16'h0000;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_mwr(logic [3:0] m);
		mwr && wr_data[5:2] == m;
	endsequence
	sequence s_done(logic [3:0] m);
		$fell(rdy_b) && kind_q == m;
	endsequence
	a_read_sets_rdy: assert property (
		rd_data_stb |=> rdy_b) else $error("ready kept after read");
	a_rise_cause: assert property (
		$rose(rdy_b) |-> $past(rd_data_stb) || $past(wr_stb) ||
		$past(wr_stb, 2)) else $error("ready rose without cause");
	a_mode_wr_high: assert property (
		mwr && rdy_b |=> rdy_b) else $error("ready low after mode write");
	a_zcal_high: assert property (
		s_mwr(MODE_ZCAL) |=> rdy_b [*3]) else $error("zero cal ready");
	a_fcal_high: assert property (
		s_mwr(MODE_FCAL) |=> rdy_b [*3]) else $error("full cal ready");
	a_single_time: assert property (
		s_done(MODE_SINGLE) |-> cnt_q >= SETTLE && cnt_q <= SETTLE + 8)
		else $error("single conversion time wrong");
	a_zcal_time: assert property (
		s_done(MODE_ZCAL) |-> cnt_q >= SETTLE && cnt_q <= SETTLE + 8)
		else $error("zero cal time wrong");
	a_fcal_time: assert property (
		s_done(MODE_FCAL) |-> cnt_q >= 4 * SETTLE &&
		cnt_q <= 4 * SETTLE + 8) else $error("full cal time wrong");
	a_data_held: assert property (
		$changed(rd_data) |-> !rdy_b || $past(wr_stb) ||
		$past(wr_stb, 2)) else $error("data changed without result");
endmodule
`default_nettype wire

// ### tb/adc_operating_mode_control_tb.sv
// testbench: host and device ends joined, driven through host requests
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	bad_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module adc_operating_mode_control_tb;
	import aomc_pkg::*;
	localparam int SIM_SETTLE = 4;
	logic sys_clk, rst_b, req, rd_req, pwr_full, gain_unity, conv_valid;
	logic busy, refused, data_valid, h_rdy_b, ref_seen, mod_run, filt_rst;
	logic in_short, in_fullscale, regs_on;
	aomc_tgt_e req_tgt;
	logic [3:0] req_ch, sel_ch, stby_en, mode, supply_en;
	logic [23:0] req_data, conv_in, data_out, offs_sel, gain_sel, rd_val;
	logic [7:0] diag_active;
	int bad_count, tests_run;
	aomc_if u_bus ();
	aomc_dev #(.SETTLE(SIM_SETTLE)) u_aomc_dev (.sys_clk(sys_clk),
		.rst_b(rst_b), .bus(u_bus), .sel_ch(sel_ch), .conv_in(conv_in),
		.conv_valid(conv_valid), .stby_en(stby_en), .mode(mode),
		.mod_run(mod_run), .filt_rst(filt_rst), .in_short(in_short),
		.in_fullscale(in_fullscale), .regs_on(regs_on),
		.supply_en(supply_en), .diag_active(diag_active),
		.offs_sel(offs_sel), .gain_sel(gain_sel));
	aomc_host u_aomc_host (.sys_clk(sys_clk), .rst_b(rst_b), .bus(u_bus),
		.req(req), .req_tgt(req_tgt), .req_ch(req_ch), .req_data(req_data),
		.rd_req(rd_req), .pwr_full(pwr_full), .gain_unity(gain_unity),
		.busy(busy), .refused(refused), .data_out(data_out),
		.data_valid(data_valid), .rdy_b(h_rdy_b));
	aomc_assertions #(.SETTLE(SIM_SETTLE)) u_aomc_assertions (
		.sys_clk(sys_clk), .rst_b(rst_b), .wr_stb(u_bus.wr_stb),
		.wr_tgt(u_bus.wr_tgt), .wr_data(u_bus.wr_data),
		.rd_data_stb(u_bus.rd_data_stb), .rd_data(u_bus.rd_data),
		.rdy_b(u_bus.rdy_b));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (refused) ref_seen <= 1'b1;
	task automatic print_verdict();
		if (bad_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic put(input aomc_tgt_e t, input logic [23:0] d);
		ref_seen = 1'b0;
		@(posedge sys_clk);
		req <= 1'b1;
		req_tgt <= t;
		req_ch <= sel_ch;
		req_data <= d;
		@(posedge sys_clk);
		req <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic ctl(input logic [3:0] m);
		put(AOMC_TGT_CTRL, {18'h00000, m, 2'b00});
	endtask
	task automatic conv(input logic [23:0] v);
		int n;
		n = 0;
		@(posedge sys_clk);
		conv_in <= v;
		conv_valid <= 1'b1;
		while (u_bus.rdy_b !== 1'b0 && n < 200) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		`CHK("conv wait", 1'b1, n < 200)
		@(posedge sys_clk);
		conv_valid <= 1'b0;
		#1;
	endtask
	task automatic rd();
		int n;
		n = 0;
		@(posedge sys_clk);
		rd_req <= 1'b1;
		@(posedge sys_clk);
		rd_req <= 1'b0;
		#1;
		`CHK("busy", 1'b1, busy)
		while (data_valid !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		`CHK("rd wait", 1'b1, n < 20)
		rd_val = data_out;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		print_verdict();
	end
	initial begin
		{rst_b, req, rd_req, pwr_full, gain_unity, conv_valid} = 6'h00;
		{ref_seen, req_ch, req_data, conv_in, stby_en} = 57'h0;
		req_tgt = AOMC_TGT_CTRL;
		sel_ch = 4'h3;
		bad_count = 0;
		tests_run = 0;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		#1;
		`CHK("mode", MODE_CONT, mode)
		`CHK("offs", OFFS_RST, offs_sel)
		conv(24'h000ABC);
		rd();
		`CHK("cont data", 24'h000ABC, rd_val)
		ctl(MODE_SINGLE);
		conv(24'h123456);
		`CHK("mode", MODE_STBY, mode)
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK("rdy", 1'b0, h_rdy_b)
		rd();
		`CHK("data", 24'h123456, rd_val)
		`CHK("rdy", 1'b1, u_bus.rdy_b)
		@(posedge sys_clk);
		stby_en <= 4'hA;
		ctl(4'hF);
		`CHK("mode", MODE_STBY, mode)
		`CHK("supply", 4'hA, supply_en)
		put(AOMC_TGT_DIAG, 24'h00003F);
		`CHK("diag", 8'h20, diag_active)
		put(AOMC_TGT_OFFS, OFFS_RST);
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			pwr_full <= (i == 0);
			gain_unity <= (i == 1);
			ctl(MODE_FCAL);
			`CHK("refused", 1'b1, ref_seen)
		end
		@(posedge sys_clk);
		{pwr_full, gain_unity} <= 2'b00;
		ctl(MODE_FCAL);
		`CHK("fullscale", 1'b1, in_fullscale)
		conv(24'h654321);
		`CHK("gain", 24'h654321, gain_sel)
		`CHK("idle", 3'h7, {filt_rst, mod_run, mode == MODE_IDLE})
		put(AOMC_TGT_DIAG, 24'h00003F);
		`CHK("diag idle", 8'h3F, diag_active)
		ctl(MODE_FCAL);
		`CHK("refused", 1'b1, ref_seen)
		ctl(MODE_ZCAL);
		`CHK("short", 1'b1, in_short)
		conv(24'h7FFF01);
		`CHK("offs", 24'h7FFF01, offs_sel)
		ctl(MODE_STBY);
		`CHK("offs", 24'h7FFF01, offs_sel)
		ctl(MODE_PDOWN);
		`CHK("regs", 1'b0, regs_on)
		`CHK("pd offs", OFFS_RST, offs_sel)
		`CHK("pd gain", GAIN_RST, gain_sel)
		`CHK("pd diag", 8'h00, diag_active)
		put(AOMC_TGT_OFFS, OFFS_RST);
		ctl(MODE_SINGLE);
		ctl(MODE_FCAL);
		`CHK("refused", 1'b1, ref_seen)
		ctl(MODE_IDLE);
		`CHK("mode", MODE_IDLE, mode)
		`CHK("rdy", 1'b1, u_bus.rdy_b)
		print_verdict();
	end
endmodule
`default_nettype wire
